// ==== fwd_pkg.sv ====
// fwd_pkg: shared constants and types for the vlan forwarding decision block.
// assumes a front-end parser that hands one frame descriptor per transfer.
package fwd_pkg;
	localparam int          NPORTS       = 8;
	localparam int          PORT_W       = 3;
	localparam int          VID_W        = 12;
	localparam int          NVID         = 4096;
	localparam int          MAC_DEPTH    = 16384;
	localparam int          L3_DEPTH     = 1024;
	localparam int          L2_DEPTH     = 256;
	localparam logic [15:0] TPID_C       = 16'h8100;
	localparam logic [15:0] TPID_S       = 16'h88a8;
	localparam logic [7:0]  OFS_CTRL     = 8'h00;
	localparam logic [7:0]  OFS_AGE      = 8'h04;
	localparam logic [7:0]  OFS_IMMLV    = 8'h08;
	localparam logic [7:0]  OFS_ROUTER   = 8'h0c;
	localparam logic [7:0]  OFS_VIDX     = 8'h10;
	localparam logic [7:0]  OFS_VCFG     = 8'h14;
	localparam logic [7:0]  OFS_KEYLO    = 8'h18;
	localparam logic [7:0]  OFS_KEYHI    = 8'h1c;
	localparam logic [7:0]  OFS_KPORTS   = 8'h20;
	localparam logic [7:0]  OFS_CMD      = 8'h24;
	localparam int          CTRL_PROV    = 0;
	localparam int          CTRL_PROXY   = 1;
	localparam int          CTRL_AGE     = 2;
	localparam int          VCFG_SN4     = 16;
	localparam int          VCFG_SN6     = 17;
	localparam int          VCFG_UFLD    = 18;
	localparam int          VCFG_ROOT    = 19;
	localparam int          CMD_UC       = 0;
	localparam int          CMD_MC       = 1;
	localparam int          CMD_VLD      = 2;
	localparam logic [31:0] AGE_RST      = 32'h11e1a300;
	localparam logic [1:0]  RESP_OKAY    = 2'b00;
	localparam logic [1:0]  RESP_SLVERR  = 2'b10;

	typedef enum logic [2:0] {
		MSG_NONE  = 3'h0,
		MSG_QUERY = 3'h1,
		MSG_HELLO = 3'h2,
		MSG_JOIN  = 3'h3,
		MSG_LEAVE = 3'h4
	} msg_t;

	typedef enum logic [2:0] {
		K_UCAST = 3'h0,
		K_FLOOD = 3'h1,
		K_MCAST = 3'h2,
		K_DROP  = 3'h3,
		K_CTRL  = 3'h4
	} kind_t;

	typedef struct packed {
		logic [PORT_W-1:0] port;
		logic [15:0]       tpid;
		logic              inner;
		logic [VID_W-1:0]  vid;
		logic [47:0]       dmac;
		logic [47:0]       smac;
		logic              is_ip;
		logic              is_v6;
		logic [127:0]      src;
		logic [127:0]      grp;
		msg_t              msg;
		logic [1:0]        ver;
	} frame_t;

	typedef struct packed {
		logic [NPORTS-1:0] ports;
		kind_t             kind;
		logic              to_router;
	} decision_t;

	function automatic logic [31:0] fold(input logic [319:0] k);
		logic [31:0] h;
		h = '0;
		for (int i = 0; i < 10; i++) begin
			h = h ^ k[i*32 +: 32];
		end
		return h;
	endfunction : fold
endpackage : fwd_pkg

// ==== vlan_fwd.sv ====
// vlan_fwd: per-vlan learning, aging, multicast lookup and snooping decision.
// assumes a parser upstream and a frame mover downstream; one clock, axi4-lite regs.
//
// The AXI4-Lite register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
module vlan_fwd
	import fwd_pkg::*;
#(
	parameter int MAC_D = MAC_DEPTH,
	parameter int L3_D  = L3_DEPTH,
	parameter int L2_D  = L2_DEPTH
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        ce,
	input  wire logic        in_valid,
	output logic             in_ready,
	input  wire frame_t      in_data,
	output logic             out_valid,
	input  wire logic        out_ready,
	output decision_t        out_data,
	input  wire logic        tc_valid,
	input  wire logic [11:0] tc_vid,
	output logic             solicit_valid,
	output logic [11:0]      solicit_vid,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [7:0]  s_axi_araddr,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp
);
	localparam int MAW = $clog2(MAC_D);
	localparam int LAW = $clog2(L3_D);
	localparam int MCW = $clog2(L2_D);

	// per-vlan state
	logic [NPORTS-1:0] memb_q [NVID];
	logic [NVID-1:0]   sn4_q, sn6_q, ufld_q, root_q;
	// unicast filtering database
	logic [59:0]       mkey_q [MAC_D];
	logic [PORT_W-1:0] mport_q [MAC_D];
	logic [MAC_D-1:0]  mvld_q, mst_q, mage_q;
	// l3 snooping table
	logic [267:0]      lkey_q [L3_D];
	logic [NPORTS-1:0] lprt_q [L3_D];
	logic [L3_D-1:0]   lvld_q;
	// l2 static multicast table
	logic [59:0]       ckey_q [L2_D];
	logic [NPORTS-1:0] cprt_q [L2_D];
	logic [L2_D-1:0]   cvld_q;
	// software registers
	logic [2:0]        ctrl_q;
	logic [31:0]       age_q, agecnt_q;
	logic [NPORTS-1:0] imm_q, router_q, kports_q;
	logic [11:0]       vidx_q;
	logic [47:0]       kmac_q;
	logic [11:0]       kvid_q;
	logic [7:0]        awa_q;
	logic [31:0]       wd_q;
	logic              aw_q, w_q;

	frame_t            f;
	decision_t         d;
	logic              acc, tag_ok, mcast, snoop, age_tick, we, lrn;
	logic [31:0]       hs, hd, hsg, hg, hc, hk;
	logic [MAW-1:0]    is, id, ik;
	logic [LAW-1:0]    isg, ig;
	logic [MCW-1:0]    ic, ikc;
	logic              dhit, sghit, ghit, chit, jhit;
	logic [LAW-1:0]    jix;
	logic [NPORTS-1:0] pbit, vm, lrem;

	assign f        = in_data;
	assign in_ready = ce && (!out_valid || out_ready);
	assign acc      = in_valid && in_ready;
	assign pbit     = NPORTS'(1) << f.port;
	assign vm       = memb_q[f.vid] & ~pbit;
	assign mcast    = f.dmac[40];
	assign tag_ok   = f.tpid == (ctrl_q[CTRL_PROV] ? TPID_S : TPID_C);
	assign snoop    = tag_ok && (f.is_v6 ? sn6_q[f.vid] : sn4_q[f.vid])
	                  && (ctrl_q[CTRL_PROV] || !f.inner);

	// hashed indices for every table
	assign hs  = fold(320'({f.vid, f.smac}));
	assign hd  = fold(320'({f.vid, f.dmac}));
	assign hsg = fold(320'({f.vid, f.grp, f.src}));
	assign hg  = fold(320'({f.vid, f.grp, 128'h0}));
	assign hc  = fold(320'({f.vid, f.dmac}));
	assign hk  = fold(320'({kvid_q, kmac_q}));
	assign is  = hs[MAW-1:0];
	assign id  = hd[MAW-1:0];
	assign ik  = hk[MAW-1:0];
	assign isg = hsg[LAW-1:0];
	assign ig  = hg[LAW-1:0];
	assign ic  = hc[MCW-1:0];
	assign ikc = hk[MCW-1:0];

	assign dhit  = mvld_q[id] && mkey_q[id] == {f.vid, f.dmac};
	assign sghit = lvld_q[isg] && lkey_q[isg] == {f.vid, f.grp, f.src};
	assign ghit  = lvld_q[ig] && lkey_q[ig] == {f.vid, f.grp, 128'h0};
	assign chit  = cvld_q[ic] && ckey_q[ic] == {f.vid, f.dmac};
	// a join or leave names a channel when a source is given, else a group
	assign jix   = (f.src != '0) ? isg : ig;
	assign jhit  = (f.src != '0) ? sghit : ghit;
	assign lrem  = lprt_q[jix] & ~pbit;
	assign lrn   = acc && tag_ok && !f.smac[40];

	always_comb begin
		d = '{ports: '0, kind: K_DROP, to_router: 1'b0};
		if (!tag_ok) begin
			d.kind = K_DROP;
		end else if (snoop && f.msg != MSG_NONE) begin
			d.kind = K_CTRL;
			if (f.msg == MSG_JOIN) begin
				d.to_router = !ctrl_q[CTRL_PROXY] || !(jhit && lprt_q[jix] != '0);
			end else if (f.msg == MSG_LEAVE) begin
				d.to_router = !ctrl_q[CTRL_PROXY] || !jhit || lrem == '0;
			end
			if (f.msg == MSG_JOIN || f.msg == MSG_LEAVE) begin
				d.ports = d.to_router ? (router_q & vm) : '0;
			end else begin
				d.ports = vm;
			end
		end else if (mcast) begin
			if (f.is_ip && sghit) begin
				d.ports = lprt_q[isg] & vm;
				d.kind  = K_MCAST;
			end else if (f.is_ip && ghit) begin
				d.ports = lprt_q[ig] & vm;
				d.kind  = K_MCAST;
			end else if (chit) begin
				d.ports = cprt_q[ic] & vm;
				d.kind  = K_MCAST;
			end else if (ufld_q[f.vid]) begin
				d.ports = vm;
				d.kind  = K_FLOOD;
			end
		end else if (dhit) begin
			d.ports = (NPORTS'(1) << mport_q[id]) & ~pbit;
			d.kind  = K_UCAST;
		end else begin
			d.ports = vm;
			d.kind  = K_FLOOD;
		end
	end

	// decision output stage
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			out_valid <= 1'b0;
			out_data  <= '0;
		end else if (ce) begin
			if (acc) begin
				out_valid <= 1'b1;
				out_data  <= d;
			end else if (out_ready) begin
				out_valid <= 1'b0;
			end
		end
	end

	// aging timer
	assign age_tick = ctrl_q[CTRL_AGE] && agecnt_q >= age_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			agecnt_q <= '0;
		end else if (ce) begin
			agecnt_q <= age_tick ? '0 : agecnt_q + 32'h1;
		end
	end

	assign we = aw_q && w_q && !s_axi_bvalid;

	// unicast database: learning, aging, static writes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mvld_q <= '0;
			mst_q  <= '0;
			mage_q <= '0;
		end else if (ce) begin
			if (age_tick) begin
				mvld_q <= mvld_q & (mage_q | mst_q);
				mage_q <= '0;
			end
			if (lrn && !(mvld_q[is] && mst_q[is])) begin
				mkey_q[is]  <= {f.vid, f.smac};
				mport_q[is] <= f.port;
				mvld_q[is]  <= 1'b1;
				mage_q[is]  <= 1'b1;
			end
			if (we && awa_q == OFS_CMD && wd_q[CMD_UC]) begin
				mkey_q[ik]  <= {kvid_q, kmac_q};
				mport_q[ik] <= kports_q[PORT_W-1:0];
				mvld_q[ik]  <= wd_q[CMD_VLD];
				mst_q[ik]   <= wd_q[CMD_VLD];
			end
		end
	end

	// static l2 multicast table
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cvld_q <= '0;
		end else if (ce && we && awa_q == OFS_CMD && wd_q[CMD_MC]) begin
			ckey_q[ikc] <= {kvid_q, kmac_q};
			cprt_q[ikc] <= kports_q;
			cvld_q[ikc] <= wd_q[CMD_VLD];
		end
	end

	// l3 table maintained by snooped joins and leaves
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lvld_q <= '0;
		end else if (ce && acc && snoop) begin
			if (f.msg == MSG_JOIN && (jhit || !lvld_q[jix])) begin
				lkey_q[jix] <= {f.vid, f.grp, f.src};
				lprt_q[jix] <= (jhit ? lprt_q[jix] : '0) | pbit;
				lvld_q[jix] <= 1'b1;
			end else if (f.msg == MSG_LEAVE && jhit && imm_q[f.port]) begin
				lprt_q[jix] <= lrem;
				lvld_q[jix] <= lrem != '0;
			end
		end
	end

	// router ports: detection sets, software write-one clears, set wins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			router_q <= '0;
		end else if (ce) begin
			router_q <= (router_q & ~((we && awa_q == OFS_ROUTER) ? wd_q[NPORTS-1:0] : '0))
			            | ((acc && snoop && (f.msg == MSG_QUERY || f.msg == MSG_HELLO))
			               ? pbit : '0);
		end
	end

	// topology change solicitation
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			solicit_valid <= 1'b0;
			solicit_vid   <= '0;
		end else if (ce) begin
			solicit_valid <= tc_valid && root_q[tc_vid];
			solicit_vid   <= tc_vid;
		end
	end

	// axi4-lite write path
	assign s_axi_awready = ce && !aw_q && !s_axi_bvalid;
	assign s_axi_wready  = ce && !w_q && !s_axi_bvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_q         <= 1'b0;
			w_q          <= 1'b0;
			awa_q        <= '0;
			wd_q         <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_q  <= 1'b1;
				awa_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_q  <= 1'b1;
				wd_q <= s_axi_wdata;
			end
			if (we) begin
				aw_q         <= 1'b0;
				w_q          <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (awa_q > OFS_CMD || awa_q[1:0] != 2'b00)
				                ? RESP_SLVERR : RESP_OKAY;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// register writes (wstrb ignored: full-word registers)
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q    <= '0;
			age_q     <= AGE_RST;
			imm_q     <= '0;
			vidx_q    <= '0;
			kmac_q    <= '0;
			kvid_q    <= '0;
			kports_q  <= '0;
			sn4_q     <= '0;
			sn6_q     <= '0;
			ufld_q    <= '0;
			root_q    <= '0;
		end else if (ce && we) begin
			unique case (awa_q)
				OFS_CTRL:   ctrl_q <= wd_q[2:0];
				OFS_AGE:    age_q <= wd_q;
				OFS_IMMLV:  imm_q <= wd_q[NPORTS-1:0];
				OFS_VIDX:   vidx_q <= wd_q[11:0];
				OFS_VCFG: begin
					memb_q[vidx_q] <= wd_q[NPORTS-1:0];
					sn4_q[vidx_q]  <= wd_q[VCFG_SN4];
					sn6_q[vidx_q]  <= wd_q[VCFG_SN6];
					ufld_q[vidx_q] <= wd_q[VCFG_UFLD];
					root_q[vidx_q] <= wd_q[VCFG_ROOT];
				end
				OFS_KEYLO:  kmac_q[31:0] <= wd_q;
				OFS_KEYHI: begin
					kmac_q[47:32] <= wd_q[15:0];
					kvid_q        <= wd_q[27:16];
				end
				OFS_KPORTS: kports_q <= wd_q[NPORTS-1:0];
				default: ;
			endcase
		end
	end

	// axi4-lite read path
	assign s_axi_arready = ce && !s_axi_rvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= RESP_OKAY;
		end else if (ce) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= RESP_OKAY;
				unique case (s_axi_araddr)
					OFS_CTRL:   s_axi_rdata <= 32'(ctrl_q);
					OFS_AGE:    s_axi_rdata <= age_q;
					OFS_IMMLV:  s_axi_rdata <= 32'(imm_q);
					OFS_ROUTER: s_axi_rdata <= 32'(router_q);
					OFS_VIDX:   s_axi_rdata <= 32'(vidx_q);
					OFS_VCFG:   s_axi_rdata <= {12'h0, root_q[vidx_q], ufld_q[vidx_q],
					                            sn6_q[vidx_q], sn4_q[vidx_q],
					                            16'(memb_q[vidx_q])};
					OFS_KEYLO:  s_axi_rdata <= kmac_q[31:0];
					OFS_KEYHI:  s_axi_rdata <= {4'h0, kvid_q, kmac_q[47:32]};
					OFS_KPORTS: s_axi_rdata <= 32'(kports_q);
					OFS_CMD:    s_axi_rdata <= '0;
					default: begin
						s_axi_rdata <= '0;
						s_axi_rresp <= RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	property p_snoop_off;
		@(posedge aclk) !aresetn |=> sn4_q == '0 && sn6_q == '0;
	endproperty
	a_snoop_off: assert property (p_snoop_off) else $error("snoop not off after reset");

	property p_router;
		@(posedge aclk) disable iff (!aresetn)
		acc && snoop && f.msg == MSG_HELLO |=> router_q[$past(f.port)];
	endproperty
	a_router: assert property (p_router) else $error("router port not marked");

	property p_unreg;
		@(posedge aclk) disable iff (!aresetn)
		acc && tag_ok && f.msg == MSG_NONE && mcast && !f.is_ip && !chit && !ufld_q[f.vid]
		|=> out_valid && out_data.ports == '0 && out_data.kind == K_DROP;
	endproperty
	a_unreg: assert property (p_unreg) else $error("unregistered multicast not dropped");

	property p_flood;
		@(posedge aclk) disable iff (!aresetn)
		acc && tag_ok && !snoop && !mcast && !dhit
		|=> out_data.kind == K_FLOOD && !out_data.ports[$past(f.port)];
	endproperty
	a_flood: assert property (p_flood) else $error("unknown unicast not flooded");

	property p_age;
		@(posedge aclk) disable iff (!aresetn)
		ce && age_tick && !lrn && !we
		|=> (mvld_q & ~($past(mage_q) | $past(mst_q))) == '0;
	endproperty
	a_age: assert property (p_age) else $error("stale entry survived aging");

	property p_tag;
		@(posedge aclk) disable iff (!aresetn)
		acc && !tag_ok |=> out_valid && out_data.kind == K_DROP;
	endproperty
	a_tag: assert property (p_tag) else $error("wrong tag type forwarded");

	property p_imm;
		@(posedge aclk) disable iff (!aresetn)
		acc && snoop && f.msg == MSG_LEAVE && jhit && imm_q[f.port]
		|=> !(lvld_q[$past(jix)] && lprt_q[$past(jix)][$past(f.port)]);
	endproperty
	a_imm: assert property (p_imm) else $error("immediate leave kept port");

	property p_sol;
		@(posedge aclk) disable iff (!aresetn)
		ce && tc_valid && root_q[tc_vid] |=> solicit_valid && solicit_vid == $past(tc_vid);
	endproperty
	a_sol: assert property (p_sol) else $error("no solicitation on topology change");

	property p_proxy;
		@(posedge aclk) disable iff (!aresetn)
		acc && snoop && ctrl_q[CTRL_PROXY] && f.msg == MSG_JOIN && jhit && lprt_q[jix] != '0
		|=> !out_data.to_router && out_data.ports == '0;
	endproperty
	a_proxy: assert property (p_proxy) else $error("repeat join sent upstream");

	c_l3hit: cover property (@(posedge aclk) acc && mcast && f.is_ip && sghit);
	c_learn: cover property (@(posedge aclk) lrn && !mvld_q[is]);
	c_leave: cover property (@(posedge aclk) acc && snoop && f.msg == MSG_LEAVE && jhit);
endmodule : vlan_fwd

// ==== port_side_model.sv ====
// port_side_model: hosts and routers on the switch ports, feeding frame descriptors
// and taking forwarding decisions.
// assumes the bench calls send right after a clock edge and drives ready_pat each cycle.
`timescale 1ns/10ps
module port_side_model
	import fwd_pkg::*;
(
	input  wire logic aclk,
	input  wire logic in_ready,
	input  wire logic ready_pat,
	output logic      in_valid,
	output frame_t    in_data,
	output logic      out_ready
);
	initial begin
		in_valid = 1'b0;
		in_data = '0;
		out_ready = 1'b1;
	end

	// prompt or stalling sink, as the bench commands
	always @(posedge aclk) begin
		out_ready <= ready_pat;
	end

	// hold the frame until taken, then scramble the idle payload
	task automatic send(input frame_t f, output int n);
		in_data <= f;
		in_valid <= 1'b1;
		@(posedge aclk);
		for (n = 0; n < 50 && in_ready !== 1'b1; n++) begin
			@(posedge aclk);
		end
		in_valid <= 1'b0;
		in_data <= ~f;
	endtask : send
endmodule : port_side_model

// ==== vlan_mac_multicast_forwarding_test.sv ====
// vlan_mac_multicast_forwarding_test: self-checking bench for the forwarding decision.
// assumes fwd_pkg, vlan_fwd and port_side_model are compiled before this file.
`timescale 1ns/10ps
module vlan_mac_multicast_forwarding_test;
	import fwd_pkg::*;
	logic        aclk, aresetn, ce, in_valid, in_ready, out_valid, out_ready, tc_valid;
	logic        solicit_valid, ready_pat, slow;
	frame_t      in_data;
	decision_t   out_data;
	logic [11:0] tc_vid, solicit_vid;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, seed;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	int          mismatches, n_checks;
	decision_t   exp_q[$];
	frame_t      f;
	localparam logic [47:0] MC = 48'h01005e000001;

	vlan_fwd vlan_fwd_i (.aclk, .aresetn, .ce, .in_valid, .in_ready, .in_data, .out_valid,
		.out_ready, .out_data, .tc_valid, .tc_vid, .solicit_valid, .solicit_vid,
		.s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
		.s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
		.s_axi_rdata, .s_axi_rresp);
	port_side_model port_side_model_i (.aclk, .in_ready, .ready_pat, .in_valid, .in_data,
		.out_ready);

	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs

	always @(posedge aclk) begin
		seed <= xs(seed);
		ready_pat <= !slow || seed[3];
	end

	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_sim

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %0t %s seen %h exp %h", $time, m, seen, exp);
		end
	endtask : check

	task automatic timeout(input int n);
		if (n >= 50) begin
			mismatches++;
			$display("MISMATCH %0t wait ran out", $time);
			end_sim();
		end
	endtask : timeout

	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		logic pa;
		logic pw;
		int   n;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		pa = 1'b1;
		pw = 1'b1;
		for (n = 0; n < 50 && s_axi_bvalid !== 1'b1; n++) begin
			@(posedge aclk);
			if (pa && s_axi_awready === 1'b1) begin
				pa = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (pw && s_axi_wready === 1'b1) begin
				pw = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
		end
		timeout(n);
		check(32'(s_axi_bresp), 32'(r), "write response");
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask : axw

	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		int n;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 50 && s_axi_rvalid !== 1'b1; n++) begin
			@(posedge aclk);
			if (s_axi_arready === 1'b1)
				s_axi_arvalid <= 1'b0;
		end
		timeout(n);
		check(s_axi_rdata, d, "read data");
		check(32'(s_axi_rresp), 32'(r), "read response");
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask : rd

	// frame from port p on vlan 5; each port owns source mac a00p
	function automatic frame_t mk(input int p, input logic [15:0] t, input logic [47:0] d,
		input logic ip, input msg_t m);
		frame_t g;
		g = '0;
		g.port = p[PORT_W-1:0];
		g.tpid = t;
		g.vid = 12'h005;
		g.dmac = d;
		g.smac = 48'h00000000a000 + 48'(p);
		g.is_ip = ip;
		g.grp = 128'he0000001;
		g.msg = m;
		g.ver = 2'h2;
		return g;
	endfunction : mk

	// note the expected decision, hand the frame over, wait for the result
	task automatic fr(input frame_t g, input logic [7:0] p, input kind_t k, input logic r);
		int n;
		exp_q.push_back(decision_t'{ports: p, kind: k, to_router: r});
		port_side_model_i.send(g, n);
		timeout(n);
		for (n = 0; n < 50 && exp_q.size() != 0; n++)
			@(posedge aclk);
		timeout(n);
		@(posedge aclk);
	endtask : fr

	always @(posedge aclk) begin
		if (aresetn === 1'b1 && out_valid === 1'b1 && out_ready === 1'b1) begin
			if (exp_q.size() == 0)
				check(32'(out_data), 32'hffffffff, "unexpected decision");
			else
				check(32'(out_data), 32'(exp_q.pop_front()), "decision");
		end
	end

	initial begin
		repeat (20000) @(posedge aclk);
		mismatches++;
		$display("MISMATCH %0t watchdog ran out", $time);
		end_sim();
	end

	initial begin
		{aresetn, tc_valid, tc_vid, slow, mismatches, n_checks} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hf;
		ce = 1'b1;
		ready_pat = 1'b1;
		seed = 32'h00013411;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(OFS_CTRL, 32'h00000000, RESP_OKAY);
		rd(OFS_AGE, AGE_RST, RESP_OKAY);
		rd(8'h28, 32'h00000000, RESP_SLVERR);
		axw(8'h2a, 32'h00000001, RESP_SLVERR);
		axw(OFS_VIDX, 32'h00000005, RESP_OKAY);
		axw(OFS_VCFG, 32'h0000000f, RESP_OKAY);
		fr(mk(3, TPID_C, MC, 1'b1, MSG_QUERY), 8'h00, K_DROP, 1'b0);
		rd(OFS_ROUTER, 32'h00000000, RESP_OKAY);
		slow <= 1'b1;
		fr(mk(1, TPID_C, 48'h00000000a002, 1'b0, MSG_NONE), 8'h0d, K_FLOOD, 1'b0);
		fr(mk(2, TPID_C, 48'h00000000a001, 1'b0, MSG_NONE), 8'h02, K_UCAST, 1'b0);
		fr(mk(2, TPID_C, 48'h00000000a002, 1'b0, MSG_NONE), 8'h00, K_UCAST, 1'b0);
		fr(mk(1, TPID_S, 48'h00000000a002, 1'b0, MSG_NONE), 8'h00, K_DROP, 1'b0);
		axw(OFS_KEYLO, 32'h00000c03, RESP_OKAY);
		axw(OFS_KEYHI, 32'h00050000, RESP_OKAY);
		axw(OFS_KPORTS, 32'h00000003, RESP_OKAY);
		axw(OFS_CMD, 32'h00000005, RESP_OKAY);
		fr(mk(2, TPID_C, 48'h000000000c03, 1'b0, MSG_NONE), 8'h08, K_UCAST, 1'b0);
		fr(mk(0, TPID_C, MC, 1'b0, MSG_NONE), 8'h00, K_DROP, 1'b0);
		axw(OFS_VCFG, 32'h0004000f, RESP_OKAY);
		fr(mk(0, TPID_C, MC, 1'b0, MSG_NONE), 8'h0e, K_FLOOD, 1'b0);
		axw(OFS_KEYLO, 32'h5e000001, RESP_OKAY);
		axw(OFS_KEYHI, 32'h00050100, RESP_OKAY);
		axw(OFS_KPORTS, 32'h0000000c, RESP_OKAY);
		axw(OFS_CMD, 32'h00000006, RESP_OKAY);
		fr(mk(0, TPID_C, MC, 1'b0, MSG_NONE), 8'h0c, K_MCAST, 1'b0);
		axw(OFS_VCFG, 32'h000d000f, RESP_OKAY);
		fr(mk(3, TPID_C, MC, 1'b1, MSG_QUERY), 8'h07, K_CTRL, 1'b0);
		rd(OFS_ROUTER, 32'h00000008, RESP_OKAY);
		fr(mk(2, TPID_C, MC, 1'b1, MSG_HELLO), 8'h0b, K_CTRL, 1'b0);
		rd(OFS_ROUTER, 32'h0000000c, RESP_OKAY);
		axw(OFS_ROUTER, 32'h00000004, RESP_OKAY);
		rd(OFS_ROUTER, 32'h00000008, RESP_OKAY);
		fr(mk(1, TPID_C, MC, 1'b1, MSG_JOIN), 8'h08, K_CTRL, 1'b1);
		fr(mk(0, TPID_C, MC, 1'b1, MSG_NONE), 8'h02, K_MCAST, 1'b0);
		f = mk(0, TPID_C, MC, 1'b1, MSG_NONE);
		f.grp = 128'he0000002;
		fr(f, 8'h0c, K_MCAST, 1'b0);
		axw(OFS_CTRL, 32'h00000002, RESP_OKAY);
		fr(mk(2, TPID_C, MC, 1'b1, MSG_JOIN), 8'h00, K_CTRL, 1'b0);
		fr(mk(0, TPID_C, MC, 1'b1, MSG_NONE), 8'h06, K_MCAST, 1'b0);
		fr(mk(2, TPID_C, MC, 1'b1, MSG_LEAVE), 8'h00, K_CTRL, 1'b0);
		axw(OFS_IMMLV, 32'h00000006, RESP_OKAY);
		fr(mk(2, TPID_C, MC, 1'b1, MSG_LEAVE), 8'h00, K_CTRL, 1'b0);
		fr(mk(0, TPID_C, MC, 1'b1, MSG_NONE), 8'h02, K_MCAST, 1'b0);
		fr(mk(1, TPID_C, MC, 1'b1, MSG_LEAVE), 8'h08, K_CTRL, 1'b1);
		f = mk(1, TPID_C, MC, 1'b1, MSG_JOIN);
		f.inner = 1'b1;
		fr(f, 8'h0c, K_MCAST, 1'b0);
		f = mk(2, TPID_C, MC, 1'b1, MSG_JOIN);
		f.src = 128'h0a000001;
		fr(f, 8'h08, K_CTRL, 1'b1);
		f = mk(0, TPID_C, MC, 1'b1, MSG_NONE);
		f.src = 128'h0a000001;
		fr(f, 8'h04, K_MCAST, 1'b0);
		tc_vid <= 12'h005;
		tc_valid <= 1'b1;
		@(posedge aclk);
		tc_valid <= 1'b0;
		@(posedge aclk);
		check(32'(solicit_valid), 32'h00000001, "solicit pulse");
		check(32'(solicit_vid), 32'h00000005, "solicit vlan");
		ce <= 1'b0;
		tc_valid <= 1'b1;
		@(posedge aclk);
		tc_valid <= 1'b0;
		@(posedge aclk);
		check(32'(solicit_valid), 32'h00000000, "solicit while frozen");
		ce <= 1'b1;
		axw(OFS_CTRL, 32'h00000001, RESP_OKAY);
		fr(mk(2, TPID_S, 48'h00000000a001, 1'b0, MSG_NONE), 8'h02, K_UCAST, 1'b0);
		fr(mk(2, TPID_C, 48'h00000000a001, 1'b0, MSG_NONE), 8'h00, K_DROP, 1'b0);
		axw(OFS_AGE, 32'h00000064, RESP_OKAY);
		rd(OFS_AGE, 32'h00000064, RESP_OKAY);
		axw(OFS_CTRL, 32'h00000004, RESP_OKAY);
		repeat (300) @(posedge aclk);
		fr(mk(2, TPID_C, 48'h00000000a001, 1'b0, MSG_NONE), 8'h0b, K_FLOOD, 1'b0);
		fr(mk(2, TPID_C, 48'h000000000c03, 1'b0, MSG_NONE), 8'h08, K_UCAST, 1'b0);
		end_sim();
	end
endmodule : vlan_mac_multicast_forwarding_test
